// >>> axmc_cfg.svh
// Constants for the axis mode and status control block.
`ifndef AXMC_CFG_SVH
`define AXMC_CFG_SVH

// ----------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------
`define AXMC_POS_W      16
`define AXMC_SPD_W      16
`define AXMC_SYNC_W     5

// ----------------------------------------------------------------------
// Bit positions of the synchronised discrete inputs
// ----------------------------------------------------------------------
`define AXMC_SYN_EN     0
`define AXMC_SYN_START  1
`define AXMC_SYN_JOGP   2
`define AXMC_SYN_JOGN   3
`define AXMC_SYN_SENS   4

// ----------------------------------------------------------------------
// Fields of output_signal_type_select
// ----------------------------------------------------------------------
`define AXMC_SIG_CUR_BIT 0
`define AXMC_SIG_INV_BIT 1

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define AXMC_POS_RST    16'h0000
`define AXMC_SPD_RST    16'h0000
`define AXMC_SYNC_RST   5'h00

`endif

// >>> axmc_ctrl_model.sv
// Supervising controller model that drives the discrete command pins.
`timescale 1ns/1ps

module axmc_ctrl_model (
  // Clock
  input  wire logic mclk,
  // Command pins
  output logic      enable,
  output logic      start,
  output logic      jog_pos,
  output logic      jog_neg,
  output logic      sensor_ok
);
  initial begin
    enable    = 1'b0;
    start     = 1'b0;
    jog_pos   = 1'b0;
    jog_neg   = 1'b0;
    sensor_ok = 1'b1;
  end

  // --------------------------------------------------------------------
  // Pin levels change just after a rising edge and then stand.
  // --------------------------------------------------------------------
  task automatic drive(input logic en, input logic st, input logic jp, input logic jn);
    @(posedge mclk);
    enable  <= en;
    start   <= st;
    jog_pos <= jp;
    jog_neg <= jn;
  endtask

  task automatic sensor(input logic ok);
    @(posedge mclk);
    sensor_ok <= ok;
  endtask
endmodule

// >>> axmc_pkg.sv
// Types and shared arithmetic of the axis mode and status control block.
`include "axmc_cfg.svh"

package axmc_pkg;

  // --------------------------------------------------------------------
  // Operating modes
  // --------------------------------------------------------------------
  typedef enum logic [3:0] {
    AXMC_OFF  = 4'h1,
    AXMC_HOLD = 4'h2,
    AXMC_AUTO = 4'h4,
    AXMC_JOG  = 4'h8
  } axmc_mode_e;

  // --------------------------------------------------------------------
  // Module state records
  // --------------------------------------------------------------------
  typedef struct packed {
    axmc_mode_e                    mode;
    logic [`AXMC_POS_W-1:0]        target;
    logic signed [`AXMC_SPD_W-1:0] jog_speed;
    logic                          err;
    logic                          ready;
    logic                          drive_en;
    logic                          ctrl_act;
    logic                          sig_cur;
    logic                          sig_inv;
    logic                          en_prev;
    logic                          start_prev;
  } axmc_state_s;

  typedef struct packed {
    logic [`AXMC_SYNC_W-1:0] stage1;
    logic [`AXMC_SYNC_W-1:0] stage2;
  } axmc_sync_s;

  typedef struct packed {
    logic in_window;
  } axmc_window_s;

  // --------------------------------------------------------------------
  // Magnitude of the distance between two positions
  // --------------------------------------------------------------------
  function automatic logic [`AXMC_POS_W-1:0] axmc_abs_diff(
    input logic [`AXMC_POS_W-1:0] a,
    input logic [`AXMC_POS_W-1:0] b
  );
    logic [`AXMC_POS_W-1:0] r;
    r = (a >= b) ? (a - b) : (b - a);
    return r;
  endfunction

endpackage

// >>> axmc_sync.sv
// Two-stage synchroniser for the discrete command pins.
`timescale 1ns/1ps
`include "axmc_cfg.svh"

module axmc_sync
  import axmc_pkg::*;
(
  // Clock and reset
  input  wire logic                    mclk,
  input  wire logic                    rst_b,
  // Pins and synchronised levels
  input  wire logic [`AXMC_SYNC_W-1:0] pins_async,
  output logic      [`AXMC_SYNC_W-1:0] pins_sync
);

  axmc_sync_s q;
  axmc_sync_s d;

  always_comb begin
    d        = q;
    d.stage1 = pins_async;
    d.stage2 = q.stage1;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      q.stage1 <= `AXMC_SYNC_RST;
      q.stage2 <= `AXMC_SYNC_RST;
    end else begin
      q <= d;
    end
  end

  assign pins_sync = q.stage2;

endmodule

// >>> axmc_top.sv
// Mode control, ready and in-position status of a closed-loop positioning axis.
`timescale 1ns/1ps
`include "axmc_cfg.svh"

// Summary of operation
// - Enable rising initialises the mode logic and clears stored errors.
// - While enabled the controller runs except in jog, ready may assert, drive is enabled.
// - Enable rising loads actual position into the commanded position.
// - Enable low switches the valve drive output off.
// - Start active runs the controller towards the external demand position.
// - Start withdrawn while moving stops within the emergency stop distance.
// - Positive jog with start low moves at the positive manual speed.
// - Negative jog with start low moves at the negative manual speed.
// - Releasing a jog input holds the axis at its present actual position.
// - Start has priority; jog requests are ignored while start is active.
// - Jog still works while the position sensor is missing.
// - Ready asserts only when enabled and no error is present.
// - Ready drops when disabled or on sensor or internal fault.
// - Status is high inside the in-position window, low outside.
// - Signal type select chooses current or voltage and output polarity.
module axmc_top
  import axmc_pkg::*;
(
  // Clock and reset
  input  wire logic                          mclk,
  input  wire logic                          rst_b,
  // Discrete command pins
  input  wire logic                          enable,
  input  wire logic                          start,
  input  wire logic                          manual_jog_positive,
  input  wire logic                          manual_jog_negative,
  // Fault sources
  input  wire logic                          sensor_present,
  input  wire logic                          internal_fault,
  // Sampled positions
  input  wire logic [`AXMC_POS_W-1:0]        pos_actual,
  input  wire logic [`AXMC_POS_W-1:0]        pos_demand,
  // Configuration
  input  wire logic signed [`AXMC_SPD_W-1:0] manual_speed_positive,
  input  wire logic signed [`AXMC_SPD_W-1:0] manual_speed_negative,
  input  wire logic [`AXMC_POS_W-1:0]        estop_distance,
  input  wire logic [`AXMC_POS_W-1:0]        in_position_window,
  input  wire logic [1:0]                    output_signal_type_select,
  // Status outputs
  output logic                               ready,
  output logic                               status,
  output logic                               error_stored,
  // Drive and controller outputs
  output logic                               drive_enable,
  output logic                               drive_current_mode,
  output logic                               drive_polarity_invert,
  output logic                               controller_active,
  output logic                               jog_active,
  output logic [`AXMC_POS_W-1:0]             pos_command,
  output logic signed [`AXMC_SPD_W-1:0]      jog_speed_cmd
);

  // --------------------------------------------------------------------
  // Input synchronisation
  // --------------------------------------------------------------------
  logic [`AXMC_SYNC_W-1:0] pins_async;
  logic [`AXMC_SYNC_W-1:0] pins_sync;
  logic                    en_s;
  logic                    st_s;
  logic                    jp_s;
  logic                    jn_s;
  logic                    sens_s;
  logic                    fault;
  logic                    in_window;

  assign pins_async = {sensor_present, manual_jog_negative, manual_jog_positive,
                       start, enable};

  axmc_sync u_sync (
    .mclk       (mclk),
    .rst_b      (rst_b),
    .pins_async (pins_async),
    .pins_sync  (pins_sync)
  );

  assign en_s   = pins_sync[`AXMC_SYN_EN];
  assign st_s   = pins_sync[`AXMC_SYN_START];
  assign jp_s   = pins_sync[`AXMC_SYN_JOGP];
  assign jn_s   = pins_sync[`AXMC_SYN_JOGN];
  assign sens_s = pins_sync[`AXMC_SYN_SENS];
  assign fault  = !sens_s || internal_fault;

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  axmc_state_s q;
  axmc_state_s d;

  // --------------------------------------------------------------------
  // In-position window
  // --------------------------------------------------------------------
  axmc_window u_window (
    .mclk       (mclk),
    .rst_b      (rst_b),
    .pos_demand (q.target),
    .pos_actual (pos_actual),
    .win_width  (in_position_window),
    .in_window  (in_window)
  );

  // --------------------------------------------------------------------
  // Mode control
  // --------------------------------------------------------------------
  always_comb begin
    logic [`AXMC_POS_W-1:0] remain;
    remain       = axmc_abs_diff(q.target, pos_actual);
    d            = q;
    d.en_prev    = en_s;
    d.start_prev = st_s;
    d.jog_speed  = `AXMC_SPD_RST;
    d.sig_cur    = output_signal_type_select[`AXMC_SIG_CUR_BIT];
    d.sig_inv    = output_signal_type_select[`AXMC_SIG_INV_BIT];
    if (!en_s) begin
      d.mode = AXMC_OFF;
    end else if (!q.en_prev) begin
      d.mode   = AXMC_HOLD;
      d.target = pos_actual;
      d.err    = fault;
    end else begin
      d.err = q.err || fault;
      if (st_s) begin
        d.mode   = AXMC_AUTO;
        d.target = pos_demand;
      end else if (q.start_prev && (q.mode == AXMC_AUTO)) begin
        d.mode = AXMC_HOLD;
        if (remain > estop_distance) begin
          if (q.target > pos_actual) begin
            d.target = pos_actual + estop_distance;
          end else begin
            d.target = pos_actual - estop_distance;
          end
        end
      end else if (jp_s && !jn_s) begin
        d.mode      = AXMC_JOG;
        d.target    = pos_actual;
        d.jog_speed = manual_speed_positive;
      end else if (jn_s && !jp_s) begin
        d.mode      = AXMC_JOG;
        d.target    = pos_actual;
        d.jog_speed = manual_speed_negative;
      end else begin
        d.mode = AXMC_HOLD;
        if (q.mode == AXMC_JOG) begin
          d.target = pos_actual;
        end
      end
    end
    d.drive_en = en_s;
    d.ctrl_act = (d.mode == AXMC_HOLD) || (d.mode == AXMC_AUTO);
    d.ready    = en_s && !d.err;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      q.mode       <= AXMC_OFF;
      q.target     <= `AXMC_POS_RST;
      q.jog_speed  <= `AXMC_SPD_RST;
      q.err        <= 1'b0;
      q.ready      <= 1'b0;
      q.drive_en   <= 1'b0;
      q.ctrl_act   <= 1'b0;
      q.sig_cur    <= 1'b0;
      q.sig_inv    <= 1'b0;
      q.en_prev    <= 1'b0;
      q.start_prev <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign ready                 = q.ready;
  assign status                = in_window;
  assign error_stored          = q.err;
  assign drive_enable          = q.drive_en;
  assign drive_current_mode    = q.sig_cur;
  assign drive_polarity_invert = q.sig_inv;
  assign controller_active     = q.ctrl_act;
  assign jog_active            = (q.mode == AXMC_JOG);
  assign pos_command           = q.target;
  assign jog_speed_cmd         = q.jog_speed;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking

  default disable iff (!rst_b);

  sequence s_enabled_run;
    en_s && q.en_prev;
  endsequence

  sequence s_jog_release;
    (q.mode == AXMC_JOG) ##0 (en_s && q.en_prev && !st_s && !(jp_s ^ jn_s));
  endsequence

  sequence s_manual;
    en_s && q.en_prev && !st_s && !(q.start_prev && (q.mode == AXMC_AUTO));
  endsequence

  property p_enable_err_clear;
    (en_s && !q.en_prev && !fault) |=> (!q.err && q.ready);
  endproperty
  a_enable_err_clear: assert property (p_enable_err_clear)
    else $error("stored error not cleared on enable");

  property p_drive_on;
    en_s |=> (drive_enable && (controller_active || jog_active));
  endproperty
  a_drive_on: assert property (p_drive_on)
    else $error("drive or controller inactive while enabled");

  property p_enable_hold;
    (en_s && !q.en_prev) |=> ((pos_command == $past(pos_actual)) && (q.mode == AXMC_HOLD));
  endproperty
  a_enable_hold: assert property (p_enable_hold)
    else $error("actual position not loaded on enable");

  property p_drive_off;
    !en_s |=> (!drive_enable && !ready && (q.mode == AXMC_OFF));
  endproperty
  a_drive_off: assert property (p_drive_off)
    else $error("drive not switched off while disabled");

  property p_auto_target;
    (s_enabled_run ##0 st_s) |=> ((pos_command == $past(pos_demand)) && !jog_active);
  endproperty
  a_auto_target: assert property (p_auto_target)
    else $error("demand position not followed under start");

  property p_estop;
    (s_enabled_run ##0 (!st_s && q.start_prev && (q.mode == AXMC_AUTO)))
      |=> (axmc_abs_diff(pos_command, $past(pos_actual)) <= $past(estop_distance));
  endproperty
  a_estop: assert property (p_estop)
    else $error("stop target beyond emergency stop distance");

  property p_jog_pos;
    (s_manual ##0 (jp_s && !jn_s))
      |=> (jog_active && (jog_speed_cmd == $past(manual_speed_positive)));
  endproperty
  a_jog_pos: assert property (p_jog_pos)
    else $error("positive jog speed not applied");

  property p_jog_neg;
    (s_manual ##0 (jn_s && !jp_s))
      |=> (jog_active && (jog_speed_cmd == $past(manual_speed_negative)));
  endproperty
  a_jog_neg: assert property (p_jog_neg)
    else $error("negative jog speed not applied");

  property p_jog_release;
    s_jog_release |=> ((pos_command == $past(pos_actual)) && (jog_speed_cmd == 0));
  endproperty
  a_jog_release: assert property (p_jog_release)
    else $error("position not captured on jog release");

  property p_ready_only_ok;
    ready |-> ($past(en_s) && !q.err);
  endproperty
  a_ready_only_ok: assert property (p_ready_only_ok)
    else $error("ready while disabled or in error");

  property p_ready_fault;
    (en_s && fault) |=> (!ready ##1 (!ready || $past(!q.en_prev)));
  endproperty
  a_ready_fault: assert property (p_ready_fault)
    else $error("ready kept through a fault");

  property p_status;
    (rst_b && (axmc_abs_diff(q.target, pos_actual) <= in_position_window)) |=> status;
  endproperty
  a_status: assert property (p_status)
    else $error("status low inside window");

  property p_status_out;
    (rst_b && (axmc_abs_diff(q.target, pos_actual) > in_position_window)) |=> !status;
  endproperty
  a_status_out: assert property (p_status_out)
    else $error("status high outside window");

  property p_sig_type;
    rst_b |=> ((drive_current_mode == $past(output_signal_type_select[0]))
              && (drive_polarity_invert == $past(output_signal_type_select[1])));
  endproperty
  a_sig_type: assert property (p_sig_type)
    else $error("signal type select not applied");

  property p_both_jog;
    (s_enabled_run ##0 (!st_s && jp_s && jn_s)) |=> (!jog_active && (jog_speed_cmd == 0));
  endproperty
  a_both_jog: assert property (p_both_jog)
    else $error("motion commanded with both jog inputs");

endmodule

// >>> axmc_window.sv
// Registered in-position window comparator.
`timescale 1ns/1ps
`include "axmc_cfg.svh"

module axmc_window
  import axmc_pkg::*;
(
  // Clock and reset
  input  wire logic                   mclk,
  input  wire logic                   rst_b,
  // Positions and window width
  input  wire logic [`AXMC_POS_W-1:0] pos_demand,
  input  wire logic [`AXMC_POS_W-1:0] pos_actual,
  input  wire logic [`AXMC_POS_W-1:0] win_width,
  // Result
  output logic                        in_window
);

  axmc_window_s q;
  axmc_window_s d;

  always_comb begin
    d           = q;
    d.in_window = (axmc_abs_diff(pos_demand, pos_actual) <= win_width);
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      q.in_window <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign in_window = q.in_window;

endmodule

// >>> test_axis_mode_and_status_control.sv
// Self-checking testbench of the axis mode and status control block.
`timescale 1ns/1ps
`include "axmc_cfg.svh"

module test_axis_mode_and_status_control;
  typedef struct {int at; int sel; logic [15:0] val;} axmc_note_t;
  localparam int k_rdy = 0, k_sts = 1, k_err = 2, k_drv = 3, k_cur = 4;
  localparam int k_inv = 5, k_ctl = 6, k_jog = 7, k_pos = 8, k_spd = 9;

  logic                          mclk, rst_b, internal_fault;
  logic                          enable, start, jog_p, jog_n, sensor_present;
  logic [`AXMC_POS_W-1:0]        pos_actual, pos_demand, estop_distance, in_position_window;
  logic signed [`AXMC_SPD_W-1:0] spd_p, spd_n, jog_speed_cmd;
  logic [1:0]                    sig_sel;
  logic                          ready, status, error_stored, drive_enable;
  logic                          drive_current_mode, drive_polarity_invert;
  logic                          controller_active, jog_active;
  logic [`AXMC_POS_W-1:0]        pos_command;
  axmc_note_t                    notes[$];
  int                            failures, cmp_count, cyc, base, seed;
  logic [15:0]                   dem[2]  = '{16'h1000, 16'h1f80};
  logic [15:0]                   stopv[2] = '{16'h1f00, 16'h1f80};
  logic [15:0]                   acts[4] = '{16'h2357, 16'h2358, 16'h2337, 16'h2336};
  logic                          stv[4]  = '{1'b1, 1'b0, 1'b1, 1'b0};

  axmc_ctrl_model u_ctrl (
    .mclk      (mclk),
    .enable    (enable),
    .start     (start),
    .jog_pos   (jog_p),
    .jog_neg   (jog_n),
    .sensor_ok (sensor_present)
  );

  axmc_top u_dut (
    .mclk                      (mclk),
    .rst_b                     (rst_b),
    .enable                    (enable),
    .start                     (start),
    .manual_jog_positive       (jog_p),
    .manual_jog_negative       (jog_n),
    .sensor_present            (sensor_present),
    .internal_fault            (internal_fault),
    .pos_actual                (pos_actual),
    .pos_demand                (pos_demand),
    .manual_speed_positive     (spd_p),
    .manual_speed_negative     (spd_n),
    .estop_distance            (estop_distance),
    .in_position_window        (in_position_window),
    .output_signal_type_select (sig_sel),
    .ready                     (ready),
    .status                    (status),
    .error_stored              (error_stored),
    .drive_enable              (drive_enable),
    .drive_current_mode        (drive_current_mode),
    .drive_polarity_invert     (drive_polarity_invert),
    .controller_active         (controller_active),
    .jog_active                (jog_active),
    .pos_command               (pos_command),
    .jog_speed_cmd             (jog_speed_cmd)
  );

  // --------------------------------------------------------------------
  // Clock, helpers and comparisons.
  // --------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic cmp_flag(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic note(input int dt, input int sel, input logic [15:0] v);
    notes.push_back('{base + dt, sel, v});
  endtask

  task automatic pins(input logic e, input logic s, input logic p, input logic n);
    u_ctrl.drive(e, s, p, n);
    base = cyc;
  endtask

  task automatic tick;
    @(posedge mclk);
    base = cyc;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // The monitor compares every note that falls due in this cycle.
  always @(negedge mclk) begin
    int         i;
    logic [7:0] flags;
    flags = {jog_active, controller_active, drive_polarity_invert, drive_current_mode,
             drive_enable, error_stored, status, ready};
    i = 0;
    while (i < notes.size()) begin
      if (notes[i].at == cyc) begin
        if (notes[i].sel < 8) cmp_flag(flags[notes[i].sel], notes[i].val[0]);
        else if (notes[i].sel == k_pos) cmp_word(pos_command, notes[i].val);
        else cmp_word(jog_speed_cmd, notes[i].val);
        notes.delete(i);
      end else begin
        i++;
      end
    end
    cyc++;
  end

  initial begin
    repeat (4000) @(posedge mclk);
    failures++;
    end_of_test;
  end

  // --------------------------------------------------------------------
  // Scenarios.
  // --------------------------------------------------------------------
  initial begin
    seed = $urandom(32'h8f3d);
    rst_b = 1'b0;
    internal_fault = 1'b0;
    pos_actual = 16'h1000;
    pos_demand = 16'h1000;
    estop_distance = 16'h0100;
    in_position_window = 16'h0010;
    spd_p = 16'($urandom);
    spd_n = 16'($urandom);
    sig_sel = 2'($urandom);
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    idle(3);
    tick;
    note(1, k_rdy, 0);
    note(1, k_drv, 0);
    pins(1, 0, 0, 0);
    note(3, k_rdy, 1);
    note(3, k_drv, 1);
    note(3, k_ctl, 1);
    note(3, k_pos, 16'h1000);
    note(6, k_sts, 1);
    idle(6);
    tick;
    internal_fault <= 1'b1;
    note(2, k_err, 1);
    note(2, k_rdy, 0);
    idle(3);
    tick;
    internal_fault <= 1'b0;
    pos_actual <= 16'h2000;
    note(3, k_err, 1);
    note(3, k_rdy, 0);
    idle(3);
    pins(0, 0, 0, 0);
    note(3, k_drv, 0);
    idle(4);
    pins(1, 0, 0, 0);
    note(3, k_err, 0);
    note(3, k_rdy, 1);
    note(3, k_pos, 16'h2000);
    idle(5);
    tick;
    pos_demand <= 16'h3000;
    pins(1, 1, 0, 0);
    note(3, k_pos, 16'h3000);
    note(3, k_ctl, 1);
    idle(4);
    tick;
    pos_demand <= 16'h3050;
    note(1, k_pos, 16'h3050);
    note(5, k_sts, 0);
    idle(5);
    pins(1, 1, 1, 0);
    note(3, k_jog, 0);
    note(3, k_spd, 0);
    note(3, k_pos, 16'h3050);
    idle(4);
    pins(1, 0, 0, 0);
    note(3, k_pos, 16'h2100);
    note(3, k_ctl, 1);
    idle(4);
    for (int i = 0; i < 2; i++) begin
      tick;
      pos_demand <= dem[i];
      pins(1, 1, 0, 0);
      idle(4);
      pins(1, 0, 0, 0);
      note(3, k_pos, stopv[i]);
      idle(4);
    end
    for (int i = 0; i < 3; i++) begin
      if (i == 2) begin
        u_ctrl.sensor(1'b0);
        base = cyc;
        note(5, k_rdy, 0);
        note(5, k_err, 1);
        idle(5);
      end
      pins(1, 0, i != 1, i == 1);
      note(3, k_jog, 1);
      note(3, k_spd, (i == 1) ? spd_n : spd_p);
      note(3, k_ctl, 0);
      idle(4);
      tick;
      pos_actual <= 16'(16'h2345 + i);
      idle(2);
      pins(1, 0, 0, 0);
      note(3, k_jog, 0);
      note(3, k_spd, 0);
      note(3, k_pos, 16'(16'h2345 + i));
      note(3, k_ctl, 1);
      idle(5);
    end
    for (int i = 0; i < 4; i++) begin
      tick;
      pos_actual <= acts[i];
      note(4, k_sts, stv[i]);
      idle(4);
    end
    u_ctrl.sensor(1'b1);
    pins(1, 0, 1, 1);
    note(3, k_jog, 0);
    note(3, k_spd, 0);
    note(3, k_ctl, 1);
    idle(5);
    for (int i = 0; i < 4; i++) begin
      tick;
      sig_sel <= 2'(i);
      note(1, k_cur, i[0]);
      note(1, k_inv, i[1]);
      idle(1);
    end
    pins(0, 0, 1, 0);
    note(3, k_drv, 0);
    note(3, k_jog, 0);
    idle(6);
    end_of_test;
  end
endmodule
